/* File: hdl/dla_top.sv */
// Data link area allocator: decodes the link parameter word and derives node allocation.
// Assumes synchronous inputs; host memory writes arrive as a strobe with data.
`timescale 1ns/1ps
`default_nettype none

module dla_top
	import dla_pkg::*;
(
	input wire logic clock, // 20 MHz clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic clk_en, // Freezes all state when low
	input wire logic [3:0] unit_no, // Unit number
	input wire logic [5:0] node_addr, // Local node address
	input wire logic is_startup, // This node starts the links
	input wire logic param_we, // Host writes parameter word
	input wire logic [15:0] param_wdata, // Parameter word write data
	input wire logic [15:0] net_param, // Parameter word from startup node
	input wire logic [5:0] man_nodes, // Manual table node count
	input wire logic [7:0] man_tx_io, // Manual io words sent
	input wire logic [7:0] man_tx_dm, // Manual dm words sent
	input wire logic [7:0] man_rx_io, // Manual io words received
	input wire logic [7:0] man_rx_dm, // Manual dm words received
	input wire logic [15:0] man_io_start, // Manual io area start
	input wire logic [15:0] man_dm_start, // Manual dm area start
	input wire logic man_table_ok, // Manual table present
	input wire logic man_contig, // Manual areas leave no gaps
	output logic [15:0] param_addr, // Word address of parameter word
	output logic [15:0] param_rdata, // Parameter word readback
	output logic links_running, // Links active
	output logic cfg_error, // Settings invalid
	output logic auto_mode, // Automatic tables in use
	output logic io_en, // io_word_area linked
	output logic dm_en, // data_memory_area linked
	output logic [5:0] node_count, // Linked nodes
	output logic node_linked, // Local node takes part
	output logic [7:0] io_words, // io words for local node
	output logic [7:0] dm_words, // dm words for local node
	output logic [7:0] io_rx_words, // io words received
	output logic [7:0] dm_rx_words, // dm words received
	output logic [15:0] io_start, // Local io area start
	output logic [15:0] dm_start, // Local dm area start
	output logic backup_we // Pulse: copy manual table to host
);

	logic [15:0] param_ff;
	logic start_d_ff;
	dla_state_e state_ff, nxt_state;
	logic [15:0] eff_param;
	logic start_bit, start_rise;
	logic [1:0] mode;
	logic [1:0] size;
	logic [5:0] n_cnt;
	logic [6:0] io_per;
	logic [7:0] dm_per;
	logic [15:0] io_base, dm_base;
	logic in_link, cfg_ok;

	function automatic logic [15:0] dla_end(input logic [15:0] base, input logic [7:0] len);
		dla_end = base + {8'h00, len} - 16'h0001;
	endfunction

	function automatic logic dla_fits(input logic [15:0] base, input logic [7:0] len, input logic [15:0] last);
		logic [16:0] e;
		e = {1'b0, base} + {9'h000, len};
		dla_fits = (len == 8'h00) || (e <= {1'b0, last} + 17'h0_0001);
	endfunction

	assign param_addr = DLA_PARAM_BASE + 16'(DLA_PARAM_STRIDE * {12'h000, unit_no});
	assign param_rdata = param_ff;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			param_ff <= DLA_PARAM_RESET;
		end else if (clk_en && param_we) begin
			param_ff <= param_wdata;
		end
	end

	// Startup node's word governs mode and size
	assign eff_param = is_startup ? param_ff : net_param;
	assign start_bit = param_ff[DLA_START_BIT];
	assign start_rise = start_bit && !start_d_ff;
	assign mode = eff_param[DLA_MODE_HI:DLA_MODE_LO];
	assign size = eff_param[DLA_SIZE_HI:DLA_SIZE_LO];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			start_d_ff <= 1'b0;
		end else if (clk_en) begin
			start_d_ff <= start_bit;
		end
	end

	// Automatic allocation from size code
	always_comb begin
		io_per = DLA_AUTO_IO_WORDS0 << size;
		dm_per = {io_per, 1'b0};
		n_cnt = DLA_AUTO_NODES0 >> size;
		in_link = (node_addr != 6'h00) && (node_addr <= n_cnt);
		io_base = DLA_AUTO_IO_BASE + 16'((node_addr - 6'h01) * io_per);
		dm_base = DLA_AUTO_DM_BASE + 16'((node_addr - 6'h01) * dm_per);
	end

	// Validity of the selected settings
	always_comb begin
		if (mode == DLA_MODE_MANUAL) begin
			cfg_ok = man_table_ok && man_contig
				&& (man_nodes >= DLA_MIN_NODES) && (man_nodes <= DLA_MAX_NODES)
				&& (man_tx_io <= DLA_MAX_WORDS) && (man_tx_dm <= DLA_MAX_WORDS)
				&& (man_rx_io <= DLA_MAX_WORDS) && (man_rx_dm <= DLA_MAX_WORDS)
				&& dla_fits(man_io_start, man_tx_io, DLA_IO_AREA_LAST)
				&& dla_fits(man_dm_start, man_tx_dm, DLA_DM_AREA_LAST);
		end else begin
			// Fixed ranges; a node past the count sits out
			// While the rest of the network still runs
			cfg_ok = !in_link || ((dla_end(io_base, {1'b0, io_per}) <= DLA_AUTO_IO_LAST)
				&& (dla_end(dm_base, dm_per) <= DLA_AUTO_DM_LAST));
		end
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			DLA_IDLE: begin
				if (start_rise) begin
					nxt_state = cfg_ok ? DLA_RUN : DLA_FAULT;
				end
			end
			DLA_RUN, DLA_FAULT: begin
				if (!start_bit) begin
					nxt_state = DLA_IDLE;
				end
			end
			default: nxt_state = DLA_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_ff <= DLA_IDLE;
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	assign links_running = (state_ff == DLA_RUN);
	assign cfg_error = (state_ff == DLA_FAULT);

	// Allocation latched on accepted start, held through the run
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			auto_mode <= 1'b0;
			io_en <= 1'b0;
			dm_en <= 1'b0;
			node_count <= 6'h00;
			node_linked <= 1'b0;
			io_words <= 8'h00;
			dm_words <= 8'h00;
			io_rx_words <= 8'h00;
			dm_rx_words <= 8'h00;
			io_start <= 16'h0000;
			dm_start <= 16'h0000;
		end else if (clk_en && state_ff == DLA_IDLE && start_rise && cfg_ok) begin
			if (mode == DLA_MODE_MANUAL) begin
				auto_mode <= 1'b0;
				io_en <= (man_tx_io != 8'h00) || (man_rx_io != 8'h00);
				dm_en <= (man_tx_dm != 8'h00) || (man_rx_dm != 8'h00);
				node_count <= man_nodes;
				node_linked <= 1'b1;
				io_words <= man_tx_io;
				dm_words <= man_tx_dm;
				io_rx_words <= man_rx_io;
				dm_rx_words <= man_rx_dm;
				io_start <= man_io_start;
				dm_start <= man_dm_start;
			end else begin
				auto_mode <= 1'b1;
				io_en <= (mode != DLA_MODE_DM_ONLY);
				dm_en <= (mode != DLA_MODE_IO_ONLY);
				node_count <= n_cnt;
				node_linked <= in_link;
				io_words <= (mode != DLA_MODE_DM_ONLY) ? {1'b0, io_per} : 8'h00;
				dm_words <= (mode != DLA_MODE_IO_ONLY) ? dm_per : 8'h00;
				io_rx_words <= (mode != DLA_MODE_DM_ONLY) ? 8'((n_cnt - 6'h01) * io_per) : 8'h00;
				dm_rx_words <= (mode != DLA_MODE_IO_ONLY) ? 8'((n_cnt - 6'h01) * dm_per) : 8'h00;
				io_start <= io_base;
				dm_start <= dm_base;
			end
		end
	end

	// Manual table copied to host settings area at start
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			backup_we <= 1'b0;
		end else if (clk_en) begin
			backup_we <= (state_ff == DLA_IDLE) && start_rise && cfg_ok && (mode == DLA_MODE_MANUAL);
		end
	end

endmodule

`default_nettype wire

/* File: inc/dla_pkg.sv */
// Package for the data link area allocator.
// Holds parameter word layout, fixed area ranges and table limits.
package dla_pkg;

	// Parameter word field positions
	localparam int DLA_START_BIT = 0;
	localparam int DLA_MODE_LO = 4;
	localparam int DLA_MODE_HI = 5;
	localparam int DLA_SIZE_LO = 6;
	localparam int DLA_SIZE_HI = 7;

	// Parameter word location: base + stride x unit number
	localparam logic [15:0] DLA_PARAM_BASE = 16'h7530;
	localparam logic [15:0] DLA_PARAM_STRIDE = 16'h0064;
	localparam logic [15:0] DLA_PARAM_RESET = 16'h0000;

	// Mode codes (bits 5:4)
	localparam logic [1:0] DLA_MODE_MANUAL = 2'h0;
	localparam logic [1:0] DLA_MODE_IO_ONLY = 2'h1;
	localparam logic [1:0] DLA_MODE_DM_ONLY = 2'h2;
	localparam logic [1:0] DLA_MODE_BOTH = 2'h3;

	// Fixed automatic ranges
	localparam logic [15:0] DLA_AUTO_IO_BASE = 16'h03E8;
	localparam logic [15:0] DLA_AUTO_IO_LAST = 16'h0427;
	localparam logic [15:0] DLA_AUTO_DM_BASE = 16'h0000;
	localparam logic [15:0] DLA_AUTO_DM_LAST = 16'h007F;

	// Manual limits
	localparam logic [15:0] DLA_IO_AREA_LAST = 16'h17FF;
	localparam logic [15:0] DLA_DM_AREA_LAST = 16'h7FFF;
	localparam logic [7:0] DLA_MAX_WORDS = 8'hFE;
	localparam logic [5:0] DLA_MAX_NODES = 6'h3E;
	localparam logic [5:0] DLA_MIN_NODES = 6'h02;

	// Automatic io words per node for size code 0; doubles per code step
	localparam logic [6:0] DLA_AUTO_IO_WORDS0 = 7'h04;
	// Automatic node count for size code 0; halves per code step
	localparam logic [5:0] DLA_AUTO_NODES0 = 6'h10;

	typedef enum logic [2:0] {
		DLA_IDLE = 3'b001,
		DLA_RUN = 3'b010,
		DLA_FAULT = 3'b100
	} dla_state_e;

endpackage

/* File: verif/dla_checker.sv */
// Port checker for the link area allocator.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module dla_checker (
	input wire logic clock, // Clock
	input wire logic sys_rst, // Reset
	input wire logic clk_en, // Enable
	input wire logic [3:0] unit_no, // Unit
	input wire logic is_startup, // Startup node
	input wire logic param_we, // Write strobe
	input wire logic [15:0] param_wdata, // Write data
	input wire logic [15:0] param_addr, // Word address
	input wire logic [15:0] param_rdata, // Stored word
	input wire logic links_running, // Running
	input wire logic cfg_error, // Bad settings
	input wire logic auto_mode, // Auto tables
	input wire logic io_en, // io area on
	input wire logic dm_en, // dm area on
	input wire logic [5:0] node_count, // Nodes
	input wire logic [7:0] io_words, // io words
	input wire logic [7:0] dm_words, // dm words
	input wire logic backup_we // Backup pulse
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	sequence s_go;
		clk_en && param_we && param_wdata[0] && !param_rdata[0] && !links_running && !cfg_error ##1 clk_en;
	endsequence
	sequence s_halt;
		clk_en && param_we && !param_wdata[0] ##1 clk_en;
	endsequence
	a_addr_calc: assert property (param_addr == 16'h7530 + unit_no * 16'h0064)
		else $error("bad word address");
	a_start_acts: assert property (s_go |=> links_running || cfg_error)
		else $error("start ignored");
	a_stop_halts: assert property (s_halt |=> !links_running)
		else $error("stop ignored");
	a_auto_runs: assert property (is_startup && param_wdata[5:4] != 2'h0 ##0 s_go |=> links_running && auto_mode)
		else $error("auto start failed");
	a_area_enable: assert property ($rose(links_running) && auto_mode && is_startup |-> io_en == param_rdata[4] && dm_en == param_rdata[5])
		else $error("area enables wrong");
	a_words_size: assert property ($rose(links_running) && auto_mode && is_startup |-> (!io_en || io_words == 8'h04 << param_rdata[7:6]) && (!dm_en || dm_words == 8'h08 << param_rdata[7:6]) && node_count == 6'h10 >> param_rdata[7:6])
		else $error("auto sizes wrong");
	a_alloc_held: assert property (links_running && $past(links_running) |-> $stable(io_words) && $stable(dm_words) && $stable(node_count))
		else $error("allocation moved");
	a_backup_once: assert property (backup_we |=> !backup_we)
		else $error("backup pulse long");
	a_backup_manual: assert property (backup_we |-> links_running && !auto_mode)
		else $error("backup outside manual");
	a_error_idle: assert property (cfg_error |-> !links_running)
		else $error("running with error");
endmodule
bind dla_top dla_checker dla_checker_i (.clock, .sys_rst, .clk_en, .unit_no, .is_startup, .param_we, .param_wdata,
	.param_addr, .param_rdata, .links_running, .cfg_error, .auto_mode, .io_en, .dm_en, .node_count, .io_words,
	.dm_words, .backup_we);
`default_nettype wire

/* File: verif/dla_host_model.sv */
// Host memory side of the allocator: issues parameter word writes.
// Assumes requests are raised by the bench just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module dla_host_model (
	input wire logic clock, // Clock
	input wire logic req, // Write request
	input wire logic [15:0] word, // Word to store
	output logic param_we, // Write strobe
	output logic [15:0] param_wdata // Write data
);
	always_ff @(posedge clock) begin
		param_we <= req;
		param_wdata <= req ? word : ~param_wdata;
	end
endmodule
`default_nettype wire

/* File: verif/dla_top_tb.sv */
// Bench for the link area allocator: auto sizes, modes, hold, manual checks.
// Assumes the host model carries every parameter word write.
`timescale 1ns/1ps
`default_nettype none
module dla_top_tb;
	import dla_pkg::*;
	logic clock = 1'b0, sys_rst = 1'b1, req = 1'b0, is_startup = 1'b1, man_table_ok, man_contig, bk = 1'b0;
	logic clk_en = 1'b1;
	logic [15:0] word = 16'h0000, net_param = 16'h0000, man_io_start = 16'h1700, param_wdata, param_addr;
	logic [15:0] param_rdata, io_start, dm_start;
	logic [7:0] man_tx_io = 8'h0A, man_rx_io = 8'h1E, w, io_words, dm_words, io_rx_words, dm_rx_words;
	logic [5:0] node_addr = 6'h02, man_nodes = 6'h3E, node_count;
	logic [3:0] unit_no = 4'h7;
	logic param_we, links_running, cfg_error, auto_mode, io_en, dm_en, node_linked, backup_we;
	int miscompares = 0, n_tests = 0;
	always #25 clock = ~clock;
	always @(negedge clock) if (backup_we === 1'b1) bk = 1'b1;
	dla_host_model dla_host_model_i (.clock, .req, .word, .param_we, .param_wdata);
	dla_top dla_top_i (.clock, .sys_rst, .clk_en, .unit_no, .node_addr, .is_startup, .param_we, .param_wdata,
		.net_param, .man_nodes, .man_tx_io, .man_tx_dm(8'h14), .man_rx_io, .man_rx_dm(8'h28), .man_io_start,
		.man_dm_start(16'h0100), .man_table_ok, .man_contig, .param_addr, .param_rdata, .links_running, .cfg_error,
		.auto_mode, .io_en, .dm_en, .node_count, .node_linked, .io_words, .dm_words, .io_rx_words, .dm_rx_words,
		.io_start, .dm_start, .backup_we);
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [15:0] d);
		word = d;
		req = 1'b1;
		@(posedge clock) #1 req = 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic complete_run;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clock);
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (3) @(posedge clock);
		#1 sys_rst = 1'b0;
		chk("rdata", 16'h0000, param_rdata);
		chk("addr", 16'h7530 + 16'h02BC, param_addr);
		for (int s = 0; s < 4; s++) begin
			w = 8'h04 << s;
			wr({8'h00, s[1:0], 6'h31});
			chk("io_words", w, io_words);
			chk("dm_words", {7'h00, w, 1'b0}, dm_words);
			chk("nodes", 16'h0010 >> s, node_count);
			chk("linked", 1'b1, node_linked);
			chk("io_start", 16'h03E8 + w, io_start);
			chk("dm_start", {7'h00, w, 1'b0}, dm_start);
			chk("io_rx", ((16'h0010 >> s) - 16'h0001) * w, io_rx_words);
			chk("dm_rx", ((16'h0010 >> s) - 16'h0001) * {7'h00, w, 1'b0}, dm_rx_words);
			chk("run_auto", 1'b1, links_running);
			chk("auto_on", 1'b1, auto_mode);
			wr(16'h0030);
			chk("run", 1'b0, links_running);
		end
		node_addr = 6'h05;
		wr(16'h00F1);
		chk("unlinked", 1'b0, node_linked);
		chk("run_unlinked", 1'b1, links_running);
		wr(16'h0030);
		node_addr = 6'h02;
		$display("auto sizes done");
		for (int m = 1; m < 3; m++) begin
			wr({10'h000, m[1:0], 4'h1});
			chk("io_en", m[0], io_en);
			chk("dm_en", m[1], dm_en);
			wr(16'h0000);
		end
		wr(16'h0011);
		wr(16'h00D1);
		chk("hold", 8'h04, io_words);
		wr(16'h0000);
		is_startup = 1'b0;
		net_param = 16'h0050;
		wr(16'h0001);
		chk("auto", 1'b1, auto_mode);
		chk("net_words", 8'h08, io_words);
		wr(16'h0000);
		is_startup = 1'b1;
		$display("modes done");
		for (int c = 0; c < 5; c++) begin
			man_table_ok = c != 1;
			man_contig = c != 2;
			man_nodes = c == 3 ? 6'h3F : 6'h3E;
			man_io_start = c == 4 ? 16'h17F8 : 16'h1700;
			bk = 1'b0;
			wr(16'h0001);
			chk("err", c != 0, cfg_error);
			chk("backup", c == 0, bk);
			chk("run_m", c == 0, links_running);
			if (c == 0) begin
				chk("tx_io", 8'h0A, io_words);
				chk("rx_io", 8'h1E, io_rx_words);
				chk("tx_dm", 8'h14, dm_words);
				chk("rx_dm", 8'h28, dm_rx_words);
				chk("m_nodes", 6'h3E, node_count);
				chk("m_io_start", 16'h1700, io_start);
				chk("m_dm_start", 16'h0100, dm_start);
				chk("m_auto", 1'b0, auto_mode);
			end
			wr(16'h0000);
		end
		$display("manual done");
		clk_en = 1'b0;
		wr(16'h0031);
		chk("frozen_rdata", 16'h0000, param_rdata);
		chk("frozen_run", 1'b0, links_running);
		clk_en = 1'b1;
		wr(16'h0031);
		chk("thawed_run", 1'b1, links_running);
		sys_rst = 1'b1;
		@(posedge clock) #1 sys_rst = 1'b0;
		chk("rst_run", 1'b0, links_running);
		chk("rst_rdata", 16'h0000, param_rdata);
		chk("rst_words", 8'h00, io_words);
		$display("enable and reset done");
		complete_run;
	end
endmodule
`default_nettype wire
